//--- design/flash_host_map.svh
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets of the controller, byte addresses.
// ----------------------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_CONFIG 8'h04
`define OFS_ADDR 8'h08
`define OFS_WDATA 8'h0c
`define OFS_RDATA 8'h10
`define OFS_STAT 8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_CLEAR 8'h1c
`define OFS_IRQ_ENABLE 8'h20

// ----------------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------------
`define CTRL_OP_LSB 0
`define STAT_BUSY_BIT 8
`define IRQ_DONE_BIT 0
`define IRQ_FAIL_BIT 1
`define CONFIG_RESET 32'h0000_0000
`define IRQ_ENABLE_RESET 2'h0

// ----------------------------------------------------------------------------
// Flash command codes.
// ----------------------------------------------------------------------------
`define CMD_READ_ARRAY 8'hff
`define CMD_READ_ID 8'h90
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_PROGRAM 8'h40
`define CMD_PROGRAM_ALT 8'h10
`define CMD_ERASE_SETUP 8'h20
`define CMD_ERASE_CONFIRM 8'hd0
`define CMD_ERASE_SUSPEND 8'hb0
`define CMD_ERASE_RESUME 8'hd0

// ----------------------------------------------------------------------------
// Flash status bit positions.
// ----------------------------------------------------------------------------
`define SR_READY_BIT 7
`define SR_SUSPENDED_BIT 6
`define SR_ERASE_FAIL_BIT 5
`define SR_PROGRAM_FAIL_BIT 4
`define SR_LOW_VPP_BIT 3
`define SR_USED_MASK 8'hf8

// ----------------------------------------------------------------------------
// Bus cycle timing in aclk cycles.
// ----------------------------------------------------------------------------
`define CYC_SETUP 8'h04
`define CYC_STROBE 8'h10
`define CYC_HOLD 8'h04

`endif

//--- design/flash_host_pkg.sv
package flash_host_pkg;

  typedef enum logic [2:0] {
    OP_READ_ARRAY,
    OP_READ_ID,
    OP_READ_STATUS,
    OP_CLEAR_STATUS,
    OP_PROGRAM,
    OP_ERASE,
    OP_SUSPEND,
    OP_RESUME
  } op_e;

  typedef enum logic [2:0] {
    S_IDLE,
    S_CMD,
    S_DATA,
    S_RD0,
    S_RD1,
    S_POLL,
    S_FIN
  } seq_state_e;

  typedef enum logic [1:0] {
    C_IDLE,
    C_SETUP,
    C_STROBE,
    C_HOLD
  } cyc_state_e;

  typedef struct packed {
    logic write;
    logic [31:0] addr;
    logic [15:0] data;
  } flash_req_s;

endpackage

//--- design/flash_bus_cycle.sv
`timescale 1ns/1ps
`include "flash_host_map.svh"

module flash_bus_cycle #(
  parameter int ADDR_W = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input flash_host_pkg::flash_req_s req,
  output logic done,
  output logic [15:0] rdata,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [15:0] dq_o,
  output logic dq_oe,
  input wire logic [15:0] dq_i,
  output logic ce_n,
  output logic oe_n,
  output logic we_n
);

  flash_host_pkg::cyc_state_e state_r;
  logic [7:0] cnt_r;
  logic write_r;

  // --------------------------------------------------------------------------
  // One asynchronous bus cycle: setup, strobe, hold.
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= flash_host_pkg::C_IDLE;
      cnt_r <= 8'h00;
      write_r <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      flash_addr <= '0;
      dq_o <= 16'h0000;
      dq_oe <= 1'b0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
    end else begin
      done <= 1'b0;
      case (state_r)
        flash_host_pkg::C_IDLE: begin
          if (go) begin
            write_r <= req.write;
            flash_addr <= req.addr[ADDR_W-1:0];
            dq_o <= req.data;
            dq_oe <= req.write;
            ce_n <= 1'b0;
            cnt_r <= `CYC_SETUP;
            state_r <= flash_host_pkg::C_SETUP;
          end
        end
        flash_host_pkg::C_SETUP: begin
          cnt_r <= cnt_r - 8'h01;
          if (cnt_r == 8'h01) begin
            we_n <= ~write_r;
            oe_n <= write_r;
            cnt_r <= `CYC_STROBE;
            state_r <= flash_host_pkg::C_STROBE;
          end
        end
        flash_host_pkg::C_STROBE: begin
          cnt_r <= cnt_r - 8'h01;
          if (cnt_r == 8'h01) begin
            // The device latches on the rising edge of the write strobe, so data stays driven through hold.
            if (!write_r) begin
              rdata <= dq_i;
            end
            we_n <= 1'b1;
            oe_n <= 1'b1;
            cnt_r <= `CYC_HOLD;
            state_r <= flash_host_pkg::C_HOLD;
          end
        end
        default: begin
          cnt_r <= cnt_r - 8'h01;
          if (cnt_r == 8'h01) begin
            ce_n <= 1'b1;
            dq_oe <= 1'b0;
            done <= 1'b1;
            state_r <= flash_host_pkg::C_IDLE;
          end
        end
      endcase
    end
  end

endmodule // flash_bus_cycle

//--- design/flash_host_ctrl.sv
`timescale 1ns/1ps
`include "flash_host_map.svh"


module flash_host_ctrl #(
  parameter int ADDR_W = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [15:0] dq_o,
  output logic dq_oe,
  input wire logic [15:0] dq_i,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic rp_n
);

  logic aw_have_r;
  logic w_have_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_en;
  logic [31:0] wmask;
  logic wr_ok;
  logic start;
  logic [31:0] config_r;
  logic [31:0] addr_r;
  logic [31:0] wdata_r;
  logic [31:0] result_r;
  logic [7:0] status_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_en_r;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  flash_host_pkg::op_e op_r;
  flash_host_pkg::seq_state_e state_r;
  logic issued_r;
  logic go;
  logic cyc_done;
  logic [15:0] cyc_rdata;
  flash_host_pkg::flash_req_s req;
  logic [31:0] rd_val;
  logic rd_ok;

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel.
  // --------------------------------------------------------------------------
  assign wr_en = aw_have_r && w_have_r && !bvalid;
  assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign wr_ok = (aw_addr_r == `OFS_CTRL) || (aw_addr_r == `OFS_CONFIG) || (aw_addr_r == `OFS_ADDR) ||
                 (aw_addr_r == `OFS_WDATA) || (aw_addr_r == `OFS_IRQ_CLEAR) || (aw_addr_r == `OFS_IRQ_ENABLE);
  assign start = wr_en && (aw_addr_r == `OFS_CTRL) && w_strb_r[0] && (state_r == flash_host_pkg::S_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else begin
      if (awvalid && awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
        wready <= 1'b0;
      end
      if (wr_en) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid <= 1'b1;
        // A start while a sequence runs is refused, since it would tear a two-cycle command apart.
        bresp <= (wr_ok && !(aw_addr_r == `OFS_CTRL && !start)) ? 2'h0 : 2'h2;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_r <= `CONFIG_RESET;
      addr_r <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
      irq_en_r <= `IRQ_ENABLE_RESET;
      op_r <= flash_host_pkg::OP_READ_ARRAY;
    end else if (wr_en) begin
      if (aw_addr_r == `OFS_CONFIG) begin
        config_r <= (config_r & ~wmask) | (w_data_r & wmask);
      end else if (aw_addr_r == `OFS_ADDR) begin
        addr_r <= (addr_r & ~wmask) | (w_data_r & wmask);
      end else if (aw_addr_r == `OFS_WDATA) begin
        wdata_r <= (wdata_r & ~wmask) | (w_data_r & wmask);
      end else if (aw_addr_r == `OFS_IRQ_ENABLE && w_strb_r[0]) begin
        irq_en_r <= w_data_r[1:0];
      end else if (start) begin
        op_r <= flash_host_pkg::op_e'(w_data_r[`CTRL_OP_LSB +: 3]);
      end
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel.
  // --------------------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (araddr == `OFS_CTRL) begin
      rd_val = {29'h0000_0000, op_r};
    end else if (araddr == `OFS_CONFIG) begin
      rd_val = config_r;
    end else if (araddr == `OFS_ADDR) begin
      rd_val = addr_r;
    end else if (araddr == `OFS_WDATA) begin
      rd_val = wdata_r;
    end else if (araddr == `OFS_RDATA) begin
      rd_val = result_r;
    end else if (araddr == `OFS_STAT) begin
      rd_val = {23'h00_0000, state_r != flash_host_pkg::S_IDLE, status_r};
    end else if (araddr == `OFS_IRQ_STATUS) begin
      rd_val = {30'h0000_0000, irq_stat_r};
    end else if (araddr == `OFS_IRQ_ENABLE) begin
      rd_val = {30'h0000_0000, irq_en_r};
    end else if (araddr != `OFS_IRQ_CLEAR) begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_val;
        rresp <= rd_ok ? 2'h0 : 2'h2;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Command sequencer.
  // --------------------------------------------------------------------------
  assign go = (state_r != flash_host_pkg::S_IDLE) && (state_r != flash_host_pkg::S_FIN) && !issued_r;

  always_comb begin
    req.write = 1'b1;
    req.addr = addr_r;
    req.data = 16'h0000;
    case (state_r)
      flash_host_pkg::S_CMD: begin
        case (op_r)
          flash_host_pkg::OP_READ_ARRAY: req.data[7:0] = `CMD_READ_ARRAY;
          flash_host_pkg::OP_READ_ID: req.data[7:0] = `CMD_READ_ID;
          flash_host_pkg::OP_READ_STATUS: req.data[7:0] = `CMD_READ_STATUS;
          flash_host_pkg::OP_CLEAR_STATUS: req.data[7:0] = `CMD_CLEAR_STATUS;
          flash_host_pkg::OP_PROGRAM: req.data[7:0] = `CMD_PROGRAM;
          flash_host_pkg::OP_ERASE: req.data[7:0] = `CMD_ERASE_SETUP;
          flash_host_pkg::OP_SUSPEND: req.data[7:0] = `CMD_ERASE_SUSPEND;
          default: req.data[7:0] = `CMD_ERASE_RESUME;
        endcase
      end
      flash_host_pkg::S_DATA: begin
        // Erase confirm goes to the same block address; any other code here would abort the erase.
        req.data = (op_r == flash_host_pkg::OP_PROGRAM) ? wdata_r[15:0] : {8'h00, `CMD_ERASE_CONFIRM};
      end
      flash_host_pkg::S_RD0: begin
        req.write = 1'b0;
        if (op_r == flash_host_pkg::OP_READ_ID) begin
          req.addr[0] = 1'b0;
        end
      end
      flash_host_pkg::S_RD1: begin
        req.write = 1'b0;
        req.addr[0] = 1'b1;
      end
      default: begin
        req.write = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= flash_host_pkg::S_IDLE;
      issued_r <= 1'b0;
      result_r <= 32'h0000_0000;
      status_r <= 8'h00;
    end else begin
      if (go) begin
        issued_r <= 1'b1;
      end
      if (cyc_done) begin
        issued_r <= 1'b0;
      end
      case (state_r)
        flash_host_pkg::S_IDLE: begin
          if (start) begin
            state_r <= flash_host_pkg::S_CMD;
          end
        end
        flash_host_pkg::S_CMD: begin
          if (cyc_done) begin
            if (op_r == flash_host_pkg::OP_CLEAR_STATUS) begin
              state_r <= flash_host_pkg::S_FIN;
            end else if (op_r == flash_host_pkg::OP_PROGRAM || op_r == flash_host_pkg::OP_ERASE) begin
              state_r <= flash_host_pkg::S_DATA;
            end else if (op_r == flash_host_pkg::OP_SUSPEND || op_r == flash_host_pkg::OP_RESUME) begin
              state_r <= flash_host_pkg::S_POLL;
            end else begin
              state_r <= flash_host_pkg::S_RD0;
            end
          end
        end
        flash_host_pkg::S_DATA: begin
          if (cyc_done) begin
            state_r <= flash_host_pkg::S_POLL;
          end
        end
        flash_host_pkg::S_RD0: begin
          if (cyc_done) begin
            result_r <= {16'h0000, cyc_rdata};
            if (op_r == flash_host_pkg::OP_READ_STATUS) begin
              status_r <= cyc_rdata[7:0] & `SR_USED_MASK;
            end
            state_r <= (op_r == flash_host_pkg::OP_READ_ID) ? flash_host_pkg::S_RD1 : flash_host_pkg::S_FIN;
          end
        end
        flash_host_pkg::S_RD1: begin
          if (cyc_done) begin
            result_r[31:16] <= cyc_rdata;
            state_r <= flash_host_pkg::S_FIN;
          end
        end
        flash_host_pkg::S_POLL: begin
          if (cyc_done) begin
            status_r <= cyc_rdata[7:0] & `SR_USED_MASK;
            result_r <= {24'h00_0000, cyc_rdata[7:0] & `SR_USED_MASK};
            // Resume returns to busy, so only the suspend and completion cases end on ready.
            if (cyc_rdata[`SR_READY_BIT] || op_r == flash_host_pkg::OP_RESUME) begin
              state_r <= flash_host_pkg::S_FIN;
            end
          end
        end
        default: begin
          state_r <= flash_host_pkg::S_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Interrupts and flash reset pin.
  // --------------------------------------------------------------------------
  // Fail is judged only after ready is seen; bits accumulate in the flash until a clear.
  assign irq_set[`IRQ_DONE_BIT] = state_r == flash_host_pkg::S_FIN;
  assign irq_set[`IRQ_FAIL_BIT] = (state_r == flash_host_pkg::S_FIN) && status_r[`SR_READY_BIT] &&
                                  (status_r[`SR_ERASE_FAIL_BIT] || status_r[`SR_PROGRAM_FAIL_BIT]);
  assign irq_clr = (wr_en && aw_addr_r == `OFS_IRQ_CLEAR && w_strb_r[0]) ? w_data_r[1:0] : 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= 2'h0;
      irq <= 1'b0;
      rp_n <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      irq <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_en_r);
      rp_n <= ~config_r[0];
    end
  end

  flash_bus_cycle #(
    .ADDR_W(ADDR_W)
  ) u_cycle (
    .aclk(aclk),
    .aresetn(aresetn),
    .go(go),
    .req(req),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .dq_o(dq_o),
    .dq_oe(dq_oe),
    .dq_i(dq_i),
    .ce_n(ce_n),
    .oe_n(oe_n),
    .we_n(we_n)
  );

endmodule // flash_host_ctrl

//--- verification/flash_host_ctrl_asserts.sv
`timescale 1ns/1ps
module flash_host_ctrl_asserts #(
  parameter int ADDR_W = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic irq,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [15:0] dq_o,
  input wire logic dq_oe,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n
);
  logic we_d;
  logic [15:0] pd;
  logic [ADDR_W-1:0] pa;

  // ----------------------------------------------------------------------------
  // Last flash write, so the follow-up write of a two-write command can be judged.
  // ----------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      we_d <= 1'b1;
      pd <= 16'h0000;
      pa <= {ADDR_W{1'b0}};
    end else begin
      we_d <= we_n;
      if (we_n && !we_d) begin
        pd <= (pd[7:0] == 8'h40 || pd[7:0] == 8'h20) ? 16'h0000 : dq_o;
        pa <= flash_addr;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_setup_count: assert property ($fell(ce_n) |-> ##4 ($fell(we_n) || $fell(oe_n)))
    else $error("strobe did not follow select after setup");
  a_write_width: assert property ($fell(we_n) |-> ##15 !we_n ##1 we_n)
    else $error("write strobe width wrong");
  a_read_width: assert property ($fell(oe_n) |-> ##15 !oe_n ##1 oe_n)
    else $error("read strobe width wrong");
  a_write_steady: assert property (!we_n && !$past(we_n) |-> $stable(dq_o) && $stable(flash_addr) && dq_oe)
    else $error("write data or address moved under strobe");
  a_read_no_drive: assert property (!oe_n |-> !dq_oe && we_n && !ce_n)
    else $error("bus driven during a read");
  a_prog_same_loc: assert property ($fell(we_n) && pd[7:0] == 8'h40 |-> flash_addr == pa)
    else $error("program data written to another location");
  a_erase_pair: assert property ($fell(we_n) && pd[7:0] == 8'h20 |-> dq_o[7:0] == 8'hd0 && flash_addr == pa)
    else $error("erase set-up not followed by confirm in the block");
  a_cmd_upper_zero: assert property ($fell(we_n) && pd[7:0] != 8'h40 |-> dq_o[15:8] == 8'h00)
    else $error("command upper byte not driven low");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |=> !awready ##1 bvalid)
    else $error("write response late");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read data late");
  a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");

  c_flash_write: cover property ($fell(we_n));
  c_id_read: cover property ($fell(oe_n) && pd[7:0] == 8'h90);
  c_irq: cover property ($rose(irq));
endmodule // flash_host_ctrl_asserts

bind flash_host_ctrl flash_host_ctrl_asserts #(.ADDR_W(ADDR_W)) u_asserts (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .irq(irq), .flash_addr(flash_addr), .dq_o(dq_o),
  .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n)
);

//--- verification/flash_device_model.sv
`timescale 1ns/1ps
module flash_device_model #(
  parameter int ADDR_W = 20,
  parameter logic [15:0] MAKER_CODE = 16'h00a5,
  parameter logic [15:0] DEVICE_CODE = 16'h5a3c,
  parameter int BUSY_READS = 2
) (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic rp_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [15:0] dq,
  input wire logic fail_inject,
  output logic [15:0] dq_q
);
  typedef enum logic [1:0] {RD_ARRAY, RD_ID, RD_STATUS} mode_e;
  mode_e mode = RD_ARRAY;
  logic [15:0] mem [16];
  logic [15:0] drv;
  logic [15:0] last = 16'h0000;
  logic fp = 1'b0;
  logic fe = 1'b0;
  logic susp = 1'b0;
  logic erasing = 1'b0;
  logic [7:0] pend = 8'h00;
  int busy = 0;
  wire logic [7:0] sr = {busy == 0 || susp, susp, fe, fp, 4'h0};

  // ----------------------------------------------------------------------------
  // Command writes; busy is counted in status reads since the part has no clock.
  // ----------------------------------------------------------------------------
  initial foreach (mem[i]) mem[i] = 16'hffff;
  always @(negedge rp_n) begin
    mode = RD_ARRAY;
    fp = 1'b0;
    fe = 1'b0;
    susp = 1'b0;
    erasing = 1'b0;
    busy = 0;
    pend = 8'h00;
  end
  always @(posedge we_n) if (!ce_n && rp_n) begin
    if (pend == 8'h40 || pend == 8'h10) begin
      mem[addr[3:0]] = mem[addr[3:0]] & dq;
      fp = fp | fail_inject;
      busy = BUSY_READS;
      mode = RD_STATUS;
      pend = 8'h00;
    end else if (pend == 8'h20) begin
      pend = 8'h00;
      mode = RD_STATUS;
      if (dq[7:0] == 8'hd0) begin
        foreach (mem[i]) mem[i] = 16'hffff;
        fe = fe | fail_inject;
        busy = BUSY_READS;
        erasing = 1'b1;
      end else begin
        fp = 1'b1;
        fe = 1'b1;
      end
    end else if (susp) begin
      case (dq[7:0])
        8'hff: mode = RD_ARRAY;
        8'h70: mode = RD_STATUS;
        8'hd0: susp = 1'b0;
        default: ;
      endcase
    end else if (busy > 0) begin
      if (dq[7:0] == 8'h70) mode = RD_STATUS;
      else if (dq[7:0] == 8'hb0 && erasing) susp = 1'b1;
    end else begin
      case (dq[7:0]) // Upper data lines are ignored for commands.
        8'hff: mode = RD_ARRAY;
        8'h90: mode = RD_ID;
        8'h70: mode = RD_STATUS;
        8'h50: begin
          fp = 1'b0;
          fe = 1'b0;
        end
        8'h40, 8'h10, 8'h20: pend = dq[7:0];
        default: ;
      endcase
    end
  end
  always @(posedge oe_n) if (!ce_n && mode == RD_STATUS && busy > 0 && !susp) begin
    busy = busy - 1;
    if (busy == 0) erasing = 1'b0;
  end
  always_comb begin
    case (mode)
      RD_STATUS: drv = {8'h00, sr};
      RD_ID: drv = addr[0] ? DEVICE_CODE : MAKER_CODE;
      default: drv = mem[addr[3:0]];
    endcase
  end
  // A released bus shows the inverse of the last value, never a friendly stale copy.
  always @(drv, ce_n, oe_n) if (!ce_n && !oe_n) last = drv;
  assign dq_q = (!ce_n && !oe_n && rp_n) ? drv : ~last;
endmodule // flash_device_model

//--- verification/test_flash_command_status_interface.sv
`timescale 1ns/1ps
`include "flash_host_map.svh"
module test_flash_command_status_interface;
  localparam logic [15:0] MAKER = 16'h00a5; // Arbitrary value.
  localparam logic [15:0] DEVICE = 16'h5a3c; // Arbitrary value.
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic fail_inject = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, dq_oe, ce_n, oe_n, we_n, rp_n;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [19:0] flash_addr;
  logic [15:0] dq_o, dq_q, dq_i;
  logic [15:0] exp_mem [16];
  logic exp_fp = 1'b0;
  logic exp_fe = 1'b0;
  int mismatches = 0;
  int comparisons = 0;

  always #2.5 aclk = ~aclk;
  assign dq_i = dq_oe ? dq_o : dq_q;

  flash_host_ctrl #(.ADDR_W(20)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq), .flash_addr(flash_addr),
    .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rp_n(rp_n)
  );
  flash_device_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) u_flash (
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rp_n(rp_n), .addr(flash_addr), .dq(dq_i),
    .fail_inject(fail_inject), .dq_q(dq_q)
  );

  // ----------------------------------------------------------------------------
  // Bus tasks and comparison.
  // ----------------------------------------------------------------------------
  function automatic logic [31:0] sr();
    return {24'h0, 2'b10, exp_fe, exp_fp, 4'h0};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  // No poll limit in the design, so only the watchdog ends a flash that stays busy.
  task automatic wait_idle();
    logic [31:0] d;
    logic [1:0] r;
    d = 32'h100;
    while (d[`STAT_BUSY_BIT]) rd(`OFS_STAT, d, r);
  endtask
  task automatic op(input logic [2:0] code);
    logic [1:0] r;
    wr(`OFS_CTRL, {29'h0, code}, r);
    check(r, 32'h0);
    wait_idle();
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [19:0] a;
    logic [15:0] v;
    void'($urandom(32'ha94f9259));
    foreach (exp_mem[i]) exp_mem[i] = 16'hffff;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFS_CONFIG, d, r);
    check(d, `CONFIG_RESET);
    rd(`OFS_IRQ_ENABLE, d, r);
    check(d, {30'h0, `IRQ_ENABLE_RESET});
    rd(8'h3c, d, r);
    check({r, d[29:0]}, 32'h8000_0000);
    wr(`OFS_STAT, 32'h1, r);
    check(r, 32'h2);
    a = $urandom;
    wr(`OFS_ADDR, {12'h0, a}, r);
    op(3'd1);
    rd(`OFS_RDATA, d, r);
    check(d, {DEVICE, MAKER});
    for (int k = 0; k < 4; k++) begin
      a = $urandom;
      v = $urandom;
      fail_inject <= (k == 1);
      wr(`OFS_IRQ_ENABLE, (k == 2) ? 32'h0 : 32'h3, r);
      wr(`OFS_ADDR, {12'h0, a}, r);
      wr(`OFS_WDATA, {16'h0, v}, r);
      op(3'd4);
      exp_mem[a[3:0]] = exp_mem[a[3:0]] & v;
      exp_fp = exp_fp | (k == 1);
      rd(`OFS_STAT, d, r);
      check(d, sr());
      check({31'h0, irq}, {31'h0, k != 2});
      rd(`OFS_IRQ_STATUS, d, r);
      check(d, {30'h0, exp_fp, 1'b1});
      wr(`OFS_IRQ_CLEAR, 32'h3, r);
      rd(`OFS_IRQ_STATUS, d, r);
      check({d[30:0], irq}, 32'h0);
      op(3'd0);
      rd(`OFS_RDATA, d, r);
      check(d[15:0], exp_mem[a[3:0]]);
    end
    op(3'd2);
    rd(`OFS_STAT, d, r);
    check(d, sr());
    op(3'd3);
    exp_fp = 1'b0;
    op(3'd2);
    rd(`OFS_STAT, d, r);
    check(d, 32'h80);
    for (int k = 0; k < 2; k++) begin
      fail_inject <= (k == 1);
      wr(`OFS_ADDR, {12'h0, a ^ k[19:0]}, r);
      op(3'd5);
      foreach (exp_mem[i]) exp_mem[i] = 16'hffff;
      exp_fe = exp_fe | (k == 1);
      rd(`OFS_STAT, d, r);
      check(d, sr());
      op(3'd0);
      rd(`OFS_RDATA, d, r);
      check(d[15:0], 16'hffff);
    end
    fail_inject <= 1'b0;
    op(3'd2);
    op(3'd6);
    rd(`OFS_STAT, d, r);
    check(d, sr());
    op(3'd7);
    op(3'd2);
    rd(`OFS_STAT, d, r);
    check(d, sr());
    wr(`OFS_CTRL, 32'h2, r);
    wr(`OFS_CTRL, 32'h2, r);
    check(r, 32'h2);
    wait_idle();
    wr(`OFS_CONFIG, 32'h1, r);
    rd(`OFS_CONFIG, d, r);
    check({d[30:0], rp_n}, 32'h2);
    wr(`OFS_CONFIG, 32'h0, r);
    exp_fe = 1'b0;
    op(3'd2);
    rd(`OFS_STAT, d, r);
    check(d, 32'h80);
    give_verdict();
  end
endmodule // test_flash_command_status_interface
